// ===== shared/led_strobe_params.svh
/*
  Constants for the LED strobe pin control block: register offsets,
  field positions, reset values and timing figures.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef LED_STROBE_PARAMS_SVH
`define LED_STROBE_PARAMS_SVH

// ==========================================================
// Register map
`define CTRL_OFFSET      4'h0
`define LIMIT_OFFSET     4'h4
`define STATUS_OFFSET    4'h8
`define REG_COUNT        2'h3

// ==========================================================
// Control fields
`define CTRL_MODE_LO     0
`define CTRL_MODE_HI     1
`define CTRL_GPIO_MODE   2
`define CTRL_PUSH_PULL   3
`define CTRL_GPIO_DIR    4
`define CTRL_GPIO_VAL    5
`define CTRL_MASK_LO     6
`define CTRL_MASK_HI     8
`define CTRL_RESET       32'h0000_01C0

// ==========================================================
// Limit fields, in ticks
`define LIMIT_FLASH_LO   0
`define LIMIT_FLASH_HI   7
`define LIMIT_WD_LO      16
`define LIMIT_WD_HI      31
`define LIMIT_RESET      32'h2710_00C8

// ==========================================================
// Status fields
`define STAT_STATE_LO    0
`define STAT_STATE_HI    3
`define STAT_FLASH       4
`define STAT_GPIO_IN     5
`define STAT_PGOOD       6
`define STAT_MASTER_RESET_LOW      7

// ==========================================================
// Timing
`define CLK_PERIOD_NS    50
`define TICK_TIME_US     1000
`define TICK_CYCLES_CALC ((`TICK_TIME_US * 1000) / `CLK_PERIOD_NS)

// ==========================================================
// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== shared/led_strobe_pkg.sv
/*
  Types shared by the LED strobe pin control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package led_strobe_pkg;

    // One-hot light states
    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_VIDEO = 4'b0010,
        ST_FLASH = 4'b0100,
        ST_HALT  = 4'b1000
    } light_state_t;

    // Software start command
    typedef enum logic [1:0] {
        SW_OFF   = 2'b00,
        SW_VIDEO = 2'b01,
        SW_FLASH = 2'b10,
        SW_RSVD  = 2'b11
    } sw_mode_t;

endpackage

`default_nettype wire

// ===== hw/led_axil_slave.sv
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the owner samples wr_en as a one-cycle strobe and drives
  rd_data combinationally from s_axi_araddr.
*/
`include "led_strobe_params.svh"
`default_nettype none

module led_axil_slave
    import led_strobe_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic        wr_en,
    output var  logic [3:0]  wr_addr,
    output var  logic [31:0] wr_data,
    output var  logic [3:0]  wr_strb,
    input  wire logic [31:0] rd_data
);

    logic        aw_held;
    logic        w_held;
    logic        next_aw_held;
    logic        next_w_held;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [3:0]  next_wr_addr;
    logic [31:0] next_wr_data;
    logic [3:0]  next_wr_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_arready;

    // ==========================================================
    // Handshakes, ready flags registered from the next state
    assign wr_en         = aw_held && w_held && !s_axi_bvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held  = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        if (wr_en)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_addr[3:2] < `REG_COUNT) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata  = rd_data;
            next_rresp  = (s_axi_araddr[3:2] < `REG_COUNT) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= 4'h0;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end
        else
        begin
            aw_held      <= next_aw_held;
            w_held       <= next_w_held;
            wr_addr      <= next_wr_addr;
            wr_data      <= next_wr_data;
            wr_strb      <= next_wr_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
        end
    end

endmodule

`default_nettype wire

// ===== hw/led_strobe_pin_control.sv
/*
  LED strobe pin control: strobe and mask pins, software start,
  flash timer, video watchdog and the general pin, with an AXI4-Lite
  register file. Assumes all pins are synchronous to sys_clk and an
  analog block reports regulation on power_in_regulation.
*/
// Behaviour
// [RQ1] Enable strobe low keeps sinks off (code: only while software mode is off or reserved; video or flash mode keeps them on)
// [RQ2] Enable strobe high turns sinks on
// [RQ3] Level strobe low flash, high video
// [RQ4] Level strobe high holds watchdog off
// [RQ5] Mask input drops flash to video
// [RQ6] Reset pin low: shutdown, registers cleared
// [RQ7] Reset pin high: registers govern operation
// [RQ8] General pin is GPIO or power good
// [RQ9] Power good open-drain or push-pull, open-drain default
// [RQ10] Start by software command or strobe
// [RQ11] Timers limit flash and video on-time
// [RQ12] Flash level returns after mask falls
`include "led_strobe_params.svh"
`default_nettype none

module led_strobe_pin_control
    import led_strobe_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES_CALC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        led_enable_strobe,
    input  wire logic        level_select_strobe,
    input  wire logic        rf_pa_mask,
    input  wire logic        master_reset_low,
    input  wire logic        power_in_regulation,
    input  wire logic        gpio_in,
    output var  logic        gpio_out,
    output var  logic        gpio_oe_n,
    output var  logic        current_sink_a,
    output var  logic        current_sink_b,
    output var  logic        current_sink_c,
    output var  logic        flash_level
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic          wr_en;
    logic [3:0]    wr_addr, wr_strb;
    logic [31:0]   wr_data, rd_data;
    logic [31:0]   ctrl, next_ctrl;
    logic [31:0]   limit, next_limit;
    light_state_t  state, next_state;
    logic [TW-1:0] div, next_div;
    logic [15:0]   tmr, next_tmr;
    logic [2:0]    sinks, next_sinks;
    logic          next_flash_level, next_gpio_out, next_gpio_oe_n;
    sw_mode_t      sw_mode;
    logic          tick, demand, want_flash, go_flash, flash_expire, wd_expire;
    // ==========================================================
    // Bus slave
    led_axil_slave u_bus (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .rd_data       (rd_data)
    );
    // ==========================================================
    // Registers
    always_comb
    begin
        next_ctrl  = ctrl;
        next_limit = limit;
        if (!master_reset_low)
        begin
            next_ctrl  = `CTRL_RESET;                         // [RQ6]
            next_limit = `LIMIT_RESET;                        // [RQ6]
        end
        else if (wr_en)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr_strb[i] && wr_addr == `CTRL_OFFSET)
                    next_ctrl[i*8 +: 8] = wr_data[i*8 +: 8];  // [RQ7]
                if (wr_strb[i] && wr_addr == `LIMIT_OFFSET)
                    next_limit[i*8 +: 8] = wr_data[i*8 +: 8]; // [RQ7]
            end
        end
    end
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (s_axi_araddr)
            `CTRL_OFFSET:   rd_data = ctrl;
            `LIMIT_OFFSET:  rd_data = limit;
            `STATUS_OFFSET:
            begin
                rd_data[`STAT_STATE_HI:`STAT_STATE_LO] = state;
                rd_data[`STAT_FLASH]   = flash_level;
                rd_data[`STAT_GPIO_IN] = gpio_in;
                rd_data[`STAT_PGOOD]   = power_in_regulation;
                rd_data[`STAT_MASTER_RESET_LOW]  = master_reset_low;
            end
            default:        rd_data = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Tick divider and light control
    assign sw_mode    = sw_mode_t'(ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    assign demand     = led_enable_strobe || sw_mode == SW_VIDEO
                        || sw_mode == SW_FLASH;              // [RQ10]
    assign want_flash = led_enable_strobe ? !level_select_strobe
                                          : sw_mode == SW_FLASH; // [RQ3]
    assign go_flash   = want_flash && !rf_pa_mask;            // [RQ5] [RQ12]
    assign tick       = div == TW'(TICK_CYCLES - 1);
    assign flash_expire = state == ST_FLASH && tick
                        && tmr == 16'(limit[`LIMIT_FLASH_HI:`LIMIT_FLASH_LO]) - 16'h0001;
    assign wd_expire  = state == ST_VIDEO && tick && !level_select_strobe
                        && tmr == limit[`LIMIT_WD_HI:`LIMIT_WD_LO] - 16'h0001;

    always_comb
    begin
        next_div   = tick ? '0 : div + TW'(1);
        next_state = state;
        case (state)
            ST_OFF:
                if (demand)
                    next_state = go_flash ? ST_FLASH : ST_VIDEO;  // [RQ2]
            ST_VIDEO:
                if (!demand)
                    next_state = ST_OFF;                          // [RQ1]
                else if (wd_expire)
                    next_state = ST_HALT;                         // [RQ11]
                else if (go_flash)
                    next_state = ST_FLASH;                        // [RQ12]
            ST_FLASH:
                if (!demand)
                    next_state = ST_OFF;                          // [RQ1]
                else if (flash_expire)
                    next_state = ST_HALT;                         // [RQ11]
                else if (!go_flash)
                    next_state = ST_VIDEO;                        // [RQ3] [RQ5]
            ST_HALT:
                if (!demand)
                    next_state = ST_OFF;
            default:
                next_state = ST_OFF;
        endcase
        if (!master_reset_low)
            next_state = ST_OFF;                                  // [RQ6]
        if (next_state != state || (state == ST_VIDEO && level_select_strobe))
            next_tmr = 16'h0000;                                  // [RQ4]
        else if (tick && (state == ST_FLASH || state == ST_VIDEO))
            next_tmr = tmr + 16'h0001;                            // [RQ11]
        else
            next_tmr = tmr;
        next_flash_level = next_state == ST_FLASH;
    end
    for (genvar g = 0; g < 3; g++)
    begin : g_sink
        assign next_sinks[g] = ctrl[`CTRL_MASK_LO + g]
                               && (next_state == ST_VIDEO || next_state == ST_FLASH);
    end
    // ==========================================================
    // General pin
    always_comb
    begin
        if (ctrl[`CTRL_GPIO_MODE])
        begin
            next_gpio_out  = ctrl[`CTRL_GPIO_VAL];                // [RQ8]
            next_gpio_oe_n = !ctrl[`CTRL_GPIO_DIR];               // [RQ8]
        end
        else if (ctrl[`CTRL_PUSH_PULL])
        begin
            next_gpio_out  = power_in_regulation;                 // [RQ9]
            next_gpio_oe_n = 1'b0;
        end
        else
        begin
            next_gpio_out  = 1'b0;                                // [RQ9]
            next_gpio_oe_n = power_in_regulation;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl        <= `CTRL_RESET;
            limit       <= `LIMIT_RESET;
            state       <= ST_OFF;
            div         <= '0;
            tmr         <= 16'h0000;
            sinks       <= 3'h0;
            flash_level <= 1'b0;
            gpio_out    <= 1'b0;
            gpio_oe_n   <= 1'b1;
        end
        else
        begin
            ctrl        <= next_ctrl;
            limit       <= next_limit;
            state       <= next_state;
            div         <= next_div;
            tmr         <= next_tmr;
            sinks       <= next_sinks;
            flash_level <= next_flash_level;
            gpio_out    <= next_gpio_out;
            gpio_oe_n   <= next_gpio_oe_n;
        end
    end
    assign current_sink_a = sinks[0];
    assign current_sink_b = sinks[1];
    assign current_sink_c = sinks[2];
    // ==========================================================
    // Checks
    sequence flash_expiring;
        state == ST_FLASH && flash_expire && demand && master_reset_low;
    endsequence
    sinks_off_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
        !led_enable_strobe && sw_mode == SW_OFF |=> !current_sink_a && !current_sink_b
        && !current_sink_c)
        else $error("sinks on without demand");
    sinks_on_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        state == ST_OFF && led_enable_strobe && master_reset_low && ctrl[`CTRL_MASK_LO]
        |=> current_sink_a)
        else $error("strobe did not start sink");
    video_level_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
        led_enable_strobe && level_select_strobe |=> !flash_level)
        else $error("flash level while video selected");
    wd_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
        state == ST_VIDEO && level_select_strobe |=> tmr == 16'h0000)
        else $error("watchdog ran while level strobe high");
    mask_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        rf_pa_mask |=> !flash_level)
        else $error("flash level under mask");
    pin_reset_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ6]
        !master_reset_low |=> state == ST_OFF && ctrl == `CTRL_RESET && !current_sink_b)
        else $error("reset pin did not clear");
    gpio_drive_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        ctrl[`CTRL_GPIO_MODE] && ctrl[`CTRL_GPIO_DIR]
        |=> !gpio_oe_n && gpio_out == $past(ctrl[`CTRL_GPIO_VAL]))
        else $error("gpio output not driven");
    pg_default_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        ctrl == `CTRL_RESET |=> !gpio_out && gpio_oe_n == $past(power_in_regulation))
        else $error("power good not open-drain");
    flash_limit_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
        flash_expiring |=> state == ST_HALT ##1 !flash_level)
        else $error("flash timer did not stop flash");
    mask_return_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ12]
        $fell(rf_pa_mask) && state == ST_VIDEO && led_enable_strobe && !level_select_strobe
        && master_reset_low && !wd_expire |=> state == ST_FLASH && flash_level)
        else $error("flash level not restored");

endmodule

`default_nettype wire

// ===== tb/strobe_host.sv
/*
  Model of the camera module that drives the strobe, mask and reset pins.
  Assumes the bench sets req just after a rising edge of sys_clk.
*/
`default_nettype none

module strobe_host
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] req,
    output var  logic       led_enable_strobe,
    output var  logic       level_select_strobe,
    output var  logic       rf_pa_mask,
    output var  logic       master_reset_low
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] next_pins;

    // ==========================================================
    // Pin drive, one cycle after request
    always_comb
    begin
        next_pins = req;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            {master_reset_low, rf_pa_mask, level_select_strobe, led_enable_strobe} <= 4'h8;
        else
            {master_reset_low, rf_pa_mask, level_select_strobe, led_enable_strobe} <= next_pins;
    end
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
/*
  Testbench for the LED strobe pin control block.
  Assumes the shared package and parameter header are compiled first.
*/
`include "led_strobe_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, led_enable_strobe, level_select_strobe;
    logic        rf_pa_mask, master_reset_low, power_in_regulation, gpio_in;
    logic        gpio_out, gpio_oe_n, flash_level;
    logic        current_sink_a, current_sink_b, current_sink_c;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, req;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          errors, n_checks;

    // Pull-up on the shared pin
    assign gpio_in = gpio_oe_n ? 1'b1 : gpio_out;

    led_strobe_pin_control #(.TICK_CYCLES(4)) u_dut (.sys_clk, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .led_enable_strobe, .level_select_strobe,
        .rf_pa_mask, .master_reset_low, .power_in_regulation, .gpio_in, .gpio_out,
        .gpio_oe_n, .current_sink_a, .current_sink_b, .current_sink_c, .flash_level);

    strobe_host u_host (.sys_clk, .rst, .req, .led_enable_strobe,
        .level_select_strobe, .rf_pa_mask, .master_reset_low);

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] pins();
        return {28'h0, current_sink_a, current_sink_b, current_sink_c,
                flash_level & current_sink_a};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdt(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        cyc(5000);
        errors++;
        end_sim();
    end

    // ==========================================================
    // Tests
    initial
    begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, power_in_regulation} = 41'h0;
        s_axi_wstrb = 4'hF;
        req = 4'h8;
        errors = 0;
        n_checks = 0;
        cyc(5);
        rst <= 1'b0;
        cyc(2);
        rdt(`CTRL_OFFSET);
        chk(rd, `CTRL_RESET);
        rdt(`LIMIT_OFFSET);
        chk(rd, `LIMIT_RESET);
        chk({30'h0, gpio_oe_n, gpio_out}, 32'h0000_0000);
        power_in_regulation <= 1'b1;
        cyc(3);
        chk({31'h0, gpio_oe_n}, 32'h0000_0001);
        rdt(`STATUS_OFFSET);
        chk({24'h0, rd[7:0]}, 32'h0000_00E1);
        rdt(4'hC);
        chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
        cyc(3);
        chk(pins(), 32'h0000_0000);
        req <= 4'h9;
        cyc(3);
        chk(pins(), 32'h0000_000F);
        req <= 4'hD;
        cyc(3);
        chk(pins(), 32'h0000_000E);
        req <= 4'h9;
        cyc(3);
        chk(pins(), 32'h0000_000F);
        req <= 4'hB;
        wr(`LIMIT_OFFSET, 32'h0003_0002);
        cyc(40);
        chk(pins(), 32'h0000_000E);
        req <= 4'h9;
        cyc(40);
        chk(pins(), 32'h0000_0000);
        rdt(`STATUS_OFFSET);
        chk({28'h0, rd[3:0]}, 32'h0000_0008);
        req <= 4'h8;
        cyc(3);
        for (int m = 1; m < 4; m++)
        begin
            wr(`CTRL_OFFSET, 32'h0000_01C0 | m);
            cyc(2);
            chk(pins(), (m == 3) ? 32'h0 : (m == 2) ? 32'h0000_000F : 32'h0000_000E);
            cyc(40);
            chk(pins(), 32'h0000_0000);
            wr(`CTRL_OFFSET, 32'h0000_01C0);
            cyc(3);
        end
        wr(`CTRL_OFFSET, 32'h0000_01F4);
        cyc(3);
        chk({30'h0, gpio_oe_n, gpio_out}, 32'h0000_0001);
        rdt(`STATUS_OFFSET);
        chk({31'h0, rd[5]}, 32'h0000_0001);
        wr(`CTRL_OFFSET, 32'h0000_01D4);
        cyc(3);
        chk({30'h0, gpio_oe_n, gpio_out}, 32'h0000_0000);
        rdt(`STATUS_OFFSET);
        chk({31'h0, rd[5]}, 32'h0000_0000);
        wr(`CTRL_OFFSET, 32'h0000_01C8);
        cyc(3);
        chk({30'h0, gpio_oe_n, gpio_out}, 32'h0000_0001);
        power_in_regulation <= 1'b0;
        cyc(3);
        chk({30'h0, gpio_oe_n, gpio_out}, 32'h0000_0000);
        req <= 4'h1;
        cyc(4);
        chk(pins(), 32'h0000_0000);
        wr(`CTRL_OFFSET, 32'h0000_01C5);
        chk({30'h0, resp}, {30'h0, `RESP_OKAY});
        rdt(`CTRL_OFFSET);
        chk(rd, `CTRL_RESET);
        rdt(`LIMIT_OFFSET);
        chk(rd, `LIMIT_RESET);
        req <= 4'h8;
        cyc(3);
        wr(`CTRL_OFFSET, 32'h0000_01C5);
        rdt(`CTRL_OFFSET);
        chk(rd, 32'h0000_01C5);
        end_sim();
    end
endmodule

`default_nettype wire
